/* hw/tsc_regs.sv */
`timescale 1ns/100ps
module tsc_regs
  import tsc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  // Arbitrary maker code, not tied to any real vendor
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter int RATE_TICK_CYC = RATE_BASE_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic CONV_DONE,
  input wire logic [11:0] REMOTE_RAW,
  input wire logic REMOTE_VALID,
  output logic CONV_START,
  output logic CONV_ABORT,
  output logic CONV_BUSY,
  output logic ALERT_ENABLE,
  output logic PIN_OVERTEMP_SEL,
  output logic RANGE_EXT,
  output logic [7:0] IDEALITY_ADJ,
  output logic [11:0] ETA_DENOM,
  output logic [11:0] REMOTE_CORR,
  output logic REMOTE_CORR_VALID
);
  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    tsc_bus_t bst;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [1:0] bidx;
    logic rd;
    logic gc;
    logic sda_o;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] ideal;
    logic [7:0] offs;
    tsc_conv_t cst;
    logic one_shot;
    logic [21:0] tick;
    logic [9:0] nticks;
    logic start;
    logic abort;
    logic busy;
    logic alert_en;
    logic pin_sel;
    logic rng;
    logic [11:0] denom;
    logic [11:0] rcorr;
    logic rvalid;
  } tsc_state_t;

  tsc_state_t cur_ff;
  tsc_state_t nxt_ff;

  function automatic logic [7:0] read_byte(input logic [7:0] ptr, input tsc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      PTR_CFG_RD: v = s.cfg;
      PTR_RATE_RD: v = s.rate;
      PTR_IDEAL: v = s.ideal;
      PTR_OFFSET: v = s.offs;
      PTR_MAKER: v = MAKER_ID;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Ticks of 1/32 s per period: code 09h is one tick, each lower code doubles it
  function automatic logic [9:0] period_ticks(input logic [7:0] code);
    logic [3:0] c;
    c = (code > RATE_MAX) ? RATE_MAX[3:0] : code[3:0];
    return 10'(10'h001 << (4'h9 - c));
  endfunction

  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic wr_pulse;
    logic soft_rst;
    logic tick_wrap;
    logic [7:0] wr_ptr;
    logic [7:0] wr_data;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_cond = 1'b0;
    stop_cond = 1'b0;
    wr_pulse = 1'b0;
    soft_rst = 1'b0;
    tick_wrap = 1'b0;
    wr_ptr = 8'h00;
    wr_data = 8'h00;
    nxt_ff = cur_ff;
    nxt_ff.scl1 = SCL_IN;
    nxt_ff.scl2 = cur_ff.scl1;
    nxt_ff.scl3 = cur_ff.scl2;
    nxt_ff.sda1 = SDA_IN;
    nxt_ff.sda2 = cur_ff.sda1;
    nxt_ff.sda3 = cur_ff.sda2;
    nxt_ff.sda_o = 1'b0;
    nxt_ff.start = 1'b0;
    nxt_ff.abort = 1'b0;
    nxt_ff.rvalid = 1'b0;
    scl_rise = cur_ff.scl2 & ~cur_ff.scl3;
    scl_fall = ~cur_ff.scl2 & cur_ff.scl3;
    start_cond = cur_ff.scl2 & cur_ff.sda3 & ~cur_ff.sda2;
    stop_cond = cur_ff.scl2 & ~cur_ff.sda3 & cur_ff.sda2;

    // Two-wire slave, sampled on the core clock
    if (start_cond)
    begin
      nxt_ff.bst = BS_RX;
      nxt_ff.cnt = 4'h0;
      nxt_ff.bidx = 2'h0;
      nxt_ff.gc = 1'b0;
      nxt_ff.rd = 1'b0;
      nxt_ff.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_ff.bst = BS_IDLE;
      nxt_ff.sda_oe = 1'b0;
    end
    else
    begin
      case (cur_ff.bst)
        BS_IDLE:
        begin
          nxt_ff.sda_oe = 1'b0;
        end
        BS_RX:
        begin
          if (scl_rise && cur_ff.cnt < 4'h8)
          begin
            nxt_ff.sh = {cur_ff.sh[6:0], cur_ff.sda2};
            nxt_ff.cnt = cur_ff.cnt + 4'h1;
          end
          else if (scl_fall && cur_ff.cnt == 4'h8)
          begin
            nxt_ff.bst = BS_ACK;
            nxt_ff.sda_oe = 1'b1;
            if (cur_ff.bidx != 2'h2)
              nxt_ff.bidx = cur_ff.bidx + 2'h1;
            if (cur_ff.bidx == 2'h0)
            begin
              if (cur_ff.sh == GC_ADDR)
                nxt_ff.gc = 1'b1;
              else if (cur_ff.sh[7:1] == DEV_ADDR)
                nxt_ff.rd = cur_ff.sh[0];
              else
              begin
                nxt_ff.bst = BS_IDLE;
                nxt_ff.sda_oe = 1'b0;
              end
            end
            else if (cur_ff.gc)
            begin
              if (cur_ff.bidx == 2'h1 && cur_ff.sh == GC_RESET)
                soft_rst = 1'b1;
            end
            else if (cur_ff.bidx == 2'h1)
              nxt_ff.ptr = cur_ff.sh;
            else
            begin
              wr_pulse = 1'b1;
              wr_ptr = cur_ff.ptr;
              wr_data = cur_ff.sh;
            end
          end
        end
        BS_ACK:
        begin
          if (scl_fall)
          begin
            nxt_ff.cnt = 4'h0;
            nxt_ff.sda_oe = 1'b0;
            nxt_ff.bst = BS_RX;
            if (cur_ff.rd)
            begin
              // Top bit goes out at once, inverted into the pull-down enable
              {nxt_ff.sda_oe, nxt_ff.tx} = {read_byte(cur_ff.ptr, cur_ff), 1'b0} ^ 9'h100;
              nxt_ff.cnt = 4'h1;
              nxt_ff.bst = BS_TX;
            end
          end
        end
        BS_TX:
        begin
          if (scl_fall)
          begin
            if (cur_ff.cnt == 4'h8)
            begin
              nxt_ff.sda_oe = 1'b0;
              nxt_ff.bst = BS_RACK;
            end
            else
            begin
              nxt_ff.sda_oe = ~cur_ff.tx[7];
              nxt_ff.tx = {cur_ff.tx[6:0], 1'b0};
              nxt_ff.cnt = cur_ff.cnt + 4'h1;
            end
          end
        end
        BS_RACK:
        begin
          if (scl_rise)
            nxt_ff.bst = cur_ff.sda2 ? BS_IDLE : BS_ACK;
        end
        default:
        begin
          nxt_ff.bst = BS_IDLE;
          nxt_ff.sda_oe = 1'b0;
        end
      endcase
    end

    // Register writes; reserved config bits are dropped
    if (wr_pulse)
    begin
      case (wr_ptr)
        PTR_CFG_WR: nxt_ff.cfg = wr_data & CFG_WR_MASK;
        PTR_RATE_WR: nxt_ff.rate = wr_data;
        PTR_IDEAL: nxt_ff.ideal = wr_data;
        PTR_OFFSET: nxt_ff.offs = wr_data;
        default: nxt_ff.rate = nxt_ff.rate;
      endcase
    end

    // Period timer runs from each conversion start, so the rate only stretches idle time
    if (cur_ff.tick == 22'(RATE_TICK_CYC - 1))
    begin
      nxt_ff.tick = 22'h000000;
      tick_wrap = 1'b1;
    end
    else
      nxt_ff.tick = cur_ff.tick + 22'h000001;
    if (tick_wrap && cur_ff.nticks != 10'h000)
      nxt_ff.nticks = cur_ff.nticks - 10'h001;

    case (cur_ff.cst)
      CS_IDLE:
      begin
        nxt_ff.start = 1'b1;
        nxt_ff.busy = 1'b1;
        nxt_ff.one_shot = 1'b0;
        nxt_ff.tick = 22'h000000;
        nxt_ff.nticks = period_ticks(cur_ff.rate);
        nxt_ff.cst = CS_CONV;
      end
      CS_CONV:
      begin
        if (CONV_DONE)
        begin
          nxt_ff.busy = 1'b0;
          if (cur_ff.cfg[CFG_HALT_BIT] || cur_ff.one_shot)
            nxt_ff.cst = CS_HALT;
          else
            nxt_ff.cst = CS_WAIT;
        end
      end
      CS_WAIT:
      begin
        if (cur_ff.cfg[CFG_HALT_BIT])
          nxt_ff.cst = CS_HALT;
        // Leave two cycles early so the start-to-start spacing is exact
        else if (cur_ff.nticks == 10'h000 || (cur_ff.nticks == 10'h001
          && cur_ff.tick == 22'(RATE_TICK_CYC - 2)))
          nxt_ff.cst = CS_IDLE;
      end
      CS_HALT:
      begin
        if (!cur_ff.cfg[CFG_HALT_BIT])
          nxt_ff.cst = CS_IDLE;
        else if (wr_pulse && wr_ptr == PTR_ONESHOT)
        begin
          // Data byte of this write is never stored
          nxt_ff.start = 1'b1;
          nxt_ff.busy = 1'b1;
          nxt_ff.one_shot = 1'b1;
          nxt_ff.cst = CS_CONV;
        end
      end
      default: nxt_ff.cst = CS_IDLE;
    endcase

    if (REMOTE_VALID)
    begin
      nxt_ff.rcorr = 12'(REMOTE_RAW + {cur_ff.offs, 4'h0});
      nxt_ff.rvalid = 1'b1;
    end

    if (soft_rst)
    begin
      nxt_ff.ptr = PTR_RST;
      nxt_ff.cfg = CFG_RST;
      nxt_ff.rate = RATE_RST;
      nxt_ff.ideal = IDEAL_RST;
      nxt_ff.offs = OFFSET_RST;
      nxt_ff.cst = CS_IDLE;
      nxt_ff.start = 1'b0;
      nxt_ff.busy = 1'b0;
      nxt_ff.abort = cur_ff.busy;
    end

    // Mask only counts while the shared pin is the alert output
    nxt_ff.alert_en = ~(nxt_ff.cfg[CFG_MASK_BIT] & ~nxt_ff.cfg[CFG_PIN_BIT]);
    nxt_ff.pin_sel = nxt_ff.cfg[CFG_PIN_BIT];
    nxt_ff.rng = nxt_ff.cfg[CFG_RANGE_BIT];
    nxt_ff.denom = 12'(ETA_BASE + {{4{nxt_ff.ideal[7]}}, nxt_ff.ideal});
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cur_ff <= '0;
      cur_ff.scl1 <= 1'b1;
      cur_ff.scl2 <= 1'b1;
      cur_ff.scl3 <= 1'b1;
      cur_ff.sda1 <= 1'b1;
      cur_ff.sda2 <= 1'b1;
      cur_ff.sda3 <= 1'b1;
      cur_ff.bst <= BS_IDLE;
      cur_ff.ptr <= PTR_RST;
      cur_ff.cfg <= CFG_RST;
      cur_ff.rate <= RATE_RST;
      cur_ff.ideal <= IDEAL_RST;
      cur_ff.offs <= OFFSET_RST;
      cur_ff.cst <= CS_IDLE;
      cur_ff.alert_en <= 1'b1;
      cur_ff.denom <= ETA_BASE;
    end
    else
      cur_ff <= nxt_ff;
  end

  assign SDA_OUT = cur_ff.sda_o;
  assign SDA_OE = cur_ff.sda_oe;
  assign CONV_START = cur_ff.start;
  assign CONV_ABORT = cur_ff.abort;
  assign CONV_BUSY = cur_ff.busy;
  assign ALERT_ENABLE = cur_ff.alert_en;
  assign PIN_OVERTEMP_SEL = cur_ff.pin_sel;
  assign RANGE_EXT = cur_ff.rng;
  assign IDEALITY_ADJ = cur_ff.ideal;
  assign ETA_DENOM = cur_ff.denom;
  assign REMOTE_CORR = cur_ff.rcorr;
  assign REMOTE_CORR_VALID = cur_ff.rvalid;
endmodule

/* hw/tsc_pkg.sv */
// Summary of operation
// - Alert mask bit 7 disables alert output
// - Mask ignored when pin is second overtemp
// - Halt bit clear: convert continuously at rate
// - Halt set: finish current conversion, then stop
// - Halt cleared again: resume continuous conversions
// - Bit 5 selects alert or second overtemp
// - Bit 2 selects standard or extended range
// - Rate code changes idle time only
// - Codes 00h-09h double rate; default 08h
// - Trigger write in shutdown runs one cycle
// - Trigger data byte is discarded
// - Signed ideality byte, read/write, resets 00h
// - Ideality scaled by 2088 over 2088+N
// - Offset added to every remote result
// - General call 06h resets all, aborts conversion
// - Other general call bytes change nothing
// - Pointer FEh reads fixed maker code
// - First written byte loads pointer; resets 00h
// - Config written at 09h, read at 03h
package tsc_pkg;
  localparam logic [7:0] PTR_CFG_RD = 8'h03;
  localparam logic [7:0] PTR_CFG_WR = 8'h09;
  localparam logic [7:0] PTR_RATE_RD = 8'h04;
  localparam logic [7:0] PTR_RATE_WR = 8'h0A;
  localparam logic [7:0] PTR_ONESHOT = 8'h0F;
  localparam logic [7:0] PTR_OFFSET = 8'h11;
  localparam logic [7:0] PTR_IDEAL = 8'h23;
  localparam logic [7:0] PTR_MAKER = 8'hFE;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h08;
  localparam logic [7:0] RATE_MAX = 8'h09;
  localparam logic [7:0] IDEAL_RST = 8'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_HALT_BIT = 6;
  localparam int CFG_PIN_BIT = 5;
  localparam int CFG_RANGE_BIT = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'hE4;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [11:0] ETA_BASE = 12'h828;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RATE_BASE_NS = 31250000;
  localparam int RATE_BASE_CYC = RATE_BASE_NS / CLK_PERIOD_NS;
  typedef enum logic [4:0] {
    BS_IDLE = 5'h01,
    BS_RX = 5'h02,
    BS_ACK = 5'h04,
    BS_TX = 5'h08,
    BS_RACK = 5'h10
  } tsc_bus_t;
  typedef enum logic [3:0] {
    CS_IDLE = 4'h1,
    CS_CONV = 4'h2,
    CS_WAIT = 4'h4,
    CS_HALT = 4'h8
  } tsc_conv_t;
endpackage

/* sim/tsc_regs_sva.sv */
`timescale 1ns/100ps
module tsc_regs_sva
  import tsc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CONV_DONE,
  input wire logic REMOTE_VALID,
  input wire logic CONV_START,
  input wire logic CONV_ABORT,
  input wire logic CONV_BUSY,
  input wire logic ALERT_ENABLE,
  input wire logic PIN_OVERTEMP_SEL,
  input wire logic RANGE_EXT,
  input wire logic [7:0] IDEALITY_ADJ,
  input wire logic [11:0] ETA_DENOM,
  input wire logic REMOTE_CORR_VALID
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_mask_ignored: assert property (PIN_OVERTEMP_SEL |-> ALERT_ENABLE)
    else $error("alert masked in overtemp pin mode");
  a_start_busy: assert property (CONV_START |-> CONV_BUSY)
    else $error("start without busy");
  a_first_start: assert property ($fell(RST) |-> ##[0:3] CONV_START)
    else $error("no conversion after reset");
  a_no_restart: assert property ($past(CONV_BUSY) && CONV_BUSY |-> !CONV_START)
    else $error("start during conversion");
  a_done_idle: assert property (CONV_BUSY && CONV_DONE |=> !CONV_BUSY)
    else $error("busy after done");
  a_busy_hold: assert property (CONV_BUSY && !CONV_DONE |=> CONV_BUSY || CONV_ABORT)
    else $error("conversion cut short");
  a_corr_pulse: assert property (REMOTE_VALID |=> REMOTE_CORR_VALID)
    else $error("no corrected result");
  a_corr_cause: assert property (REMOTE_CORR_VALID |-> $past(REMOTE_VALID))
    else $error("corrected result without raw");
  a_eta_denom: assert property (ETA_DENOM == ETA_BASE + {{4{IDEALITY_ADJ[7]}}, IDEALITY_ADJ})
    else $error("denominator mismatch");
  a_reset_vals: assert property ($fell(RST) |-> ALERT_ENABLE && !PIN_OVERTEMP_SEL
    && !RANGE_EXT && IDEALITY_ADJ == IDEAL_RST)
    else $error("bad reset values");
  a_abort_busy: assert property (CONV_ABORT |-> $past(CONV_BUSY))
    else $error("abort while idle");
endmodule

bind tsc_regs tsc_regs_sva u_sva (.CORE_CLK(CORE_CLK), .RST(RST), .CONV_DONE(CONV_DONE),
  .REMOTE_VALID(REMOTE_VALID), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT),
  .CONV_BUSY(CONV_BUSY), .ALERT_ENABLE(ALERT_ENABLE), .PIN_OVERTEMP_SEL(PIN_OVERTEMP_SEL),
  .RANGE_EXT(RANGE_EXT), .IDEALITY_ADJ(IDEALITY_ADJ), .ETA_DENOM(ETA_DENOM),
  .REMOTE_CORR_VALID(REMOTE_CORR_VALID));

/* sim/tsc_fe_model.sv */
`timescale 1ns/100ps
module tsc_fe_model #(
  parameter int LAT = 6,
  parameter logic [11:0] RAW = 12'h1A3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  output logic done = 1'b0,
  output logic valid = 1'b0,
  output logic [11:0] raw = 12'h000
);
  int cnt = 0;
  always @(posedge clk)
  begin
    done <= 1'b0;
    valid <= 1'b0;
    // Result bus toggles outside its pulse so stale data never looks valid
    raw <= rst ? 12'h000 : (cnt == 1) ? RAW : ~raw;
    if (rst || abort)
      cnt <= 0;
    else if (start)
      cnt <= LAT;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      done <= (cnt == 1);
      valid <= (cnt == 1);
    end
  end
endmodule

/* sim/tsc_regs_tb.sv */
`timescale 1ns/100ps
module tsc_regs_tb;
  import tsc_pkg::*;
  localparam int TICK = 20;
  localparam logic [6:0] ADR = 7'h2A;
  localparam logic [7:0] MID = 8'h3C; // Arbitrary maker code
  localparam logic [11:0] RAW = 12'h1A3;
  logic clk = 0;
  logic rst = 1;
  logic scl = 1;
  logic sda_m = 1;
  logic sda_oe, done, rvalid, cstart, cabort, busy, alert_en, pin_sel, range_ext, cvalid;
  logic [7:0] ideal;
  logic [11:0] raw, eta, corr;
  wire sda = sda_m & ~sda_oe;
  int n_errors = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n_start = 0;
  int n_abort = 0;
  int t_last = 0;
  int period = 0;
  int n0;
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cabort)
      n_abort <= n_abort + 1;
    if (cstart)
    begin
      n_start <= n_start + 1;
      period <= cyc_n - t_last;
      t_last <= cyc_n;
    end
  end
  tsc_regs #(.MAKER_ID(MID), .RATE_TICK_CYC(TICK)) dut (.CORE_CLK(clk), .RST(rst),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .CONV_DONE(done),
    .REMOTE_RAW(raw), .REMOTE_VALID(rvalid), .CONV_START(cstart), .CONV_ABORT(cabort),
    .CONV_BUSY(busy), .ALERT_ENABLE(alert_en), .PIN_OVERTEMP_SEL(pin_sel),
    .RANGE_EXT(range_ext), .IDEALITY_ADJ(ideal), .ETA_DENOM(eta), .REMOTE_CORR(corr),
    .REMOTE_CORR_VALID(cvalid));
  tsc_fe_model #(.RAW(RAW)) u_fe (.clk(clk), .rst(rst), .start(cstart), .abort(cabort),
    .done(done), .valid(rvalid), .raw(raw));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drv(input logic s, input logic c, input int n);
    sda_m = s;
    scl = c;
    cyc(n);
  endtask
  task automatic start_c;
    drv(1, 0, 2);
    drv(1, 1, 3);
    drv(0, 1, 3);
    drv(0, 0, 2);
  endtask
  task automatic stop_c;
    drv(0, 0, 2);
    drv(0, 1, 3);
    drv(1, 1, 3);
  endtask
  task automatic xbit(input logic b, output logic r);
    drv(b, 0, 2);
    drv(b, 1, 3);
    r = sda;
    drv(b, 1, 2);
    drv(b, 0, 3);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, ack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    start_c;
    wbyte({ADR, 1'b0}, a);
    wbyte(p, a);
    wbyte(d, a);
    stop_c;
    cyc(3);
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    // Pointer is set by a write before every read
    start_c;
    wbyte({ADR, 1'b0}, a);
    wbyte(p, a);
    start_c;
    wbyte({ADR, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, d[i]);
    xbit(1'b1, a);
    stop_c;
    cyc(3);
    chk(16'(d), 16'(exp));
  endtask
  task automatic gc_cmd(input logic [7:0] b);
    logic a;
    start_c;
    wbyte(GC_ADDR, a);
    chk(16'(a), 16'h0000);
    wbyte(b, a);
    stop_c;
    cyc(3);
  endtask
  task automatic meas(input int exp);
    n0 = n_start;
    for (int i = 0; i < 30000 && n_start < n0 + 2; i++)
      cyc(1);
    chk(16'(n_start - n0), 16'h0002);
    chk(16'(period), 16'(exp));
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #800000;
    n_errors++;
    test_done;
  end
  initial
  begin
    cyc(8);
    rst = 0;
    cyc(5);
    rchk(PTR_CFG_RD, CFG_RST);
    rchk(PTR_RATE_RD, RATE_RST);
    rchk(PTR_IDEAL, IDEAL_RST);
    rchk(PTR_MAKER, MID);
    chk(16'({eta, alert_en}), 16'h1051);
    meas(TICK << 1);
    wr(PTR_CFG_WR, 8'hA4);
    chk(16'({alert_en, pin_sel, range_ext}), 16'h0007);
    wr(PTR_CFG_WR, 8'h80);
    chk(16'({alert_en, pin_sel, range_ext}), 16'h0000);
    rchk(PTR_CFG_RD, 8'h80);
    wr(PTR_IDEAL, 8'h80);
    rchk(PTR_IDEAL, 8'h80);
    chk(16'(eta), 16'h07A8);
    wr(PTR_IDEAL, 8'h7F);
    chk(16'(ideal), 16'h007F);
    chk(16'(eta), 16'h08A7);
    wr(PTR_OFFSET, 8'h05);
    for (int i = 0; i < 2000 && cvalid !== 1'b1; i++)
      cyc(1);
    chk(16'(cvalid), 16'h0001);
    chk(16'(corr), 16'(RAW + 12'h050));
    for (int c = 0; c <= 9; c++)
    begin
      wr(PTR_RATE_WR, 8'(c));
      rchk(PTR_RATE_RD, 8'(c));
      meas(TICK << (9 - c));
    end
    wr(PTR_CFG_WR, 8'h40);
    cyc(20);
    n0 = n_start;
    cyc(200);
    chk(16'(n_start - n0), 16'h0000);
    chk(16'(busy), 16'h0000);
    wr(PTR_ONESHOT, 8'h5A);
    cyc(200);
    chk(16'(n_start - n0), 16'h0001);
    rchk(PTR_ONESHOT, 8'h00);
    wr(PTR_CFG_WR, 8'h00);
    meas(TICK);
    gc_cmd(8'h01);
    rchk(PTR_RATE_RD, 8'h09);
    chk(16'(ideal), 16'h007F);
    chk(16'(n_abort), 16'h0000);
    gc_cmd(GC_RESET);
    rchk(PTR_RATE_RD, RATE_RST);
    chk(16'(ideal), 16'h0000);
    chk(16'(eta), 16'h0828);
    meas(TICK << 1);
    test_done;
  end
endmodule
